// *** tmc_pkg.sv ***
`default_nettype none
package tmc_pkg;
    // channel count and register widths
    localparam int unsigned NUM_CH = 5;
    localparam int unsigned PRE_W = 10;

    // byte offsets; channel c sits at base + 4*c
    localparam logic [11:0] OFF_MODE_BASE = 12'h000;
    localparam logic [11:0] OFF_IOAB_BASE = 12'h020;
    localparam logic [11:0] OFF_IOCD_BASE = 12'h040;
    localparam logic [11:0] OFF_CSEL3 = 12'h060;
    localparam logic [11:0] OFF_CSEL4 = 12'h064;

    // reset values
    localparam logic [7:0] MODE_RST = 8'hc0;
    localparam logic [7:0] IOC_RST = 8'h00;
    localparam logic [2:0] CSEL_RST = 3'h0;

    // field positions
    localparam int unsigned BUF_B_BIT = 5;
    localparam int unsigned BUF_A_BIT = 4;
    localparam int unsigned IO_UPPER_LSB = 4;
    localparam int unsigned IO_LOWER_LSB = 0;

    // clock select codes for channels 3 and 4
    localparam logic [2:0] CSEL_DIV1 = 3'h0;
    localparam logic [2:0] CSEL_DIV4 = 3'h1;
    localparam logic [2:0] CSEL_DIV16 = 3'h2;
    localparam logic [2:0] CSEL_DIV64 = 3'h3;
    localparam logic [2:0] CSEL_DIV256 = 3'h4;
    localparam logic [2:0] CSEL_DIV1024 = 3'h5;
    localparam logic [2:0] CSEL_EXT_A = 3'h6;
    localparam logic [2:0] CSEL_EXT_B = 3'h7;

    // operating mode field codes
    localparam logic [3:0] MD_NORMAL = 4'h0;
    localparam logic [3:0] MD_PWM1 = 4'h2;
    localparam logic [3:0] MD_PWM2 = 4'h3;
    localparam logic [3:0] MD_PHASE1 = 4'h4;
    localparam logic [3:0] MD_PHASE2 = 4'h5;
    localparam logic [3:0] MD_PHASE3 = 4'h6;
    localparam logic [3:0] MD_PHASE4 = 4'h7;
    localparam logic [3:0] MD_RSYNC = 4'h8;
    localparam logic [3:0] MD_CPEAK = 4'hd;
    localparam logic [3:0] MD_CVALLEY = 4'he;
    localparam logic [3:0] MD_CBOTH = 4'hf;

    typedef enum logic [3:0] {
        MODE_NORMAL, MODE_PWM1, MODE_PWM2, MODE_PHASE1, MODE_PHASE2, MODE_PHASE3,
        MODE_PHASE4, MODE_RSYNC, MODE_COMP_PEAK, MODE_COMP_VALLEY, MODE_COMP_BOTH,
        MODE_RESERVED
    } tmc_mode_t;

    // effective configuration handed to one channel's counter datapath
    typedef struct packed {
        tmc_mode_t mode;
        logic buf_a;
        logic buf_b;
        logic gen_c_live;
        logic gen_d_live;
        logic [3:0] io_a;
        logic [3:0] io_b;
        logic [3:0] io_c;
        logic [3:0] io_d;
    } tmc_chan_cfg_t;

    // channels with general registers c and d
    function automatic logic tmc_has_cd(input int unsigned ch);
        return (ch == 0) || (ch == 3) || (ch == 4);
    endfunction
endpackage
`default_nettype wire

// *** tmc_mode_dec.sv ***
`default_nettype none
module tmc_mode_dec
    import tmc_pkg::*;
#(
    parameter int unsigned CH = 0
) (
    // raw field
    input wire logic [3:0] mode_field,
    // decoded result
    output var tmc_mode_t mode,
    output logic illegal
);
    // codes a channel cannot run fall to reserved and raise illegal
    always_comb begin
        mode = MODE_RESERVED;
        case (mode_field)
            MD_NORMAL: mode = MODE_NORMAL;
            MD_PWM1: mode = MODE_PWM1;
            MD_PWM2: mode = (CH == 3 || CH == 4) ? MODE_RESERVED : MODE_PWM2;
            MD_PHASE1: mode = (CH == 1 || CH == 2) ? MODE_PHASE1 : MODE_RESERVED;
            MD_PHASE2: mode = (CH == 1 || CH == 2) ? MODE_PHASE2 : MODE_RESERVED;
            MD_PHASE3: mode = (CH == 1 || CH == 2) ? MODE_PHASE3 : MODE_RESERVED;
            MD_PHASE4: mode = (CH == 1 || CH == 2) ? MODE_PHASE4 : MODE_RESERVED;
            MD_RSYNC: mode = (CH == 3) ? MODE_RSYNC : MODE_RESERVED;
            MD_CPEAK: mode = (CH == 3) ? MODE_COMP_PEAK : MODE_RESERVED;
            MD_CVALLEY: mode = (CH == 3) ? MODE_COMP_VALLEY : MODE_RESERVED;
            MD_CBOTH: mode = (CH == 3) ? MODE_COMP_BOTH : MODE_RESERVED;
            default: mode = MODE_RESERVED;
        endcase
        illegal = (mode == MODE_RESERVED);
    end
endmodule
`default_nettype wire

// *** tmc_top.sv ***
// Summary of operation
// - codes 000-100 select divide 1..256
// - codes 110/111 count on external pins
// - code 101 selects divide by 1024
// - mode registers reset to c0 hex
// - mode bits 7,6 read one, unwritable
// - bit 5 buffers b with d
// - bit 4 buffers a with c
// - channels 1,2 buffer bits read zero
// - 0000 normal, 0010 pwm1, 0011 pwm2
// - phase counting only on channels 1,2
// - 1000 reset-sync, 1101-1111 complementary pwm
// - channel 3 only; channel 4 follows it
// - io control registers reset to zero
// - upper nibble b, lower nibble a
// - low register: upper d, lower c
// - buffered c/d ignore io settings
`default_nettype none
module tmc_top
    import tmc_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // standby entry reinitialises mode and io control registers like power-on, but not the clock selects
    input wire logic standby_req,
    // external count pins
    input wire logic ext_count_pin_a,
    input wire logic ext_count_pin_b,
    // count enables for channels 3 and 4
    output logic count_tick_3,
    output logic count_tick_4,
    // effective channel configuration
    output var tmc_chan_cfg_t chan_cfg [NUM_CH],
    output logic [NUM_CH-1:0] mode_illegal
);
    // register storage; mode keeps only its six writable bits
    logic [5:0] mode_lo_r [NUM_CH];
    logic [7:0] ioab_r [NUM_CH];
    logic [7:0] iocd_r [NUM_CH];
    logic [2:0] csel3_r;
    logic [2:0] csel4_r;
    logic [PRE_W-1:0] pre_cnt_r;
    logic ext_a_q_r;
    logic ext_b_q_r;

    // decode results
    tmc_mode_t dec_mode [NUM_CH];
    logic [NUM_CH-1:0] dec_bad;
    logic coupled3;
    logic [2:0] csel4_eff;

    // address decode
    logic [2:0] reg_ch;
    logic ch_ok;
    logic hit_mode;
    logic hit_ioab;
    logic hit_iocd;
    logic hit_csel3;
    logic hit_csel4;
    logic hit_any;
    logic wr_go;

    // mode register read value, reserved bits forced
    function automatic logic [7:0] mode_rd(input int unsigned ch, input logic [5:0] v);
        logic [1:0] bufs;
        bufs = tmc_has_cd(ch) ? v[BUF_B_BIT:BUF_A_BIT] : 2'b00;
        return {MODE_RST[7:6], bufs, v[3:0]};
    endfunction

    // counter enable for one clock select code
    function automatic logic tick_for(input logic [2:0] sel, input logic [PRE_W-1:0] cnt,
                                      input logic rise_a, input logic rise_b);
        logic t;
        t = 1'b0;
        case (sel)
            CSEL_DIV1: t = 1'b1;
            CSEL_DIV4: t = (cnt[1:0] == 2'h0);
            CSEL_DIV16: t = (cnt[3:0] == 4'h0);
            CSEL_DIV64: t = (cnt[5:0] == 6'h00);
            CSEL_DIV256: t = (cnt[7:0] == 8'h00);
            CSEL_DIV1024: t = (cnt == 10'h000);
            CSEL_EXT_A: t = rise_a;
            CSEL_EXT_B: t = rise_b;
            default: t = 1'b0;
        endcase
        return t;
    endfunction

    // each channel occupies one word per bank
    assign reg_ch = paddr[4:2];
    assign ch_ok = (reg_ch < 3'(NUM_CH)) && (paddr[1:0] == 2'b00);
    assign hit_mode = ch_ok && (paddr[11:5] == OFF_MODE_BASE[11:5]);
    assign hit_ioab = ch_ok && (paddr[11:5] == OFF_IOAB_BASE[11:5]);
    assign hit_iocd = ch_ok && (paddr[11:5] == OFF_IOCD_BASE[11:5]) && tmc_has_cd(reg_ch);
    assign hit_csel3 = (paddr == OFF_CSEL3);
    assign hit_csel4 = (paddr == OFF_CSEL4);
    assign hit_any = hit_mode || hit_ioab || hit_iocd || hit_csel3 || hit_csel4;

    // zero-wait slave; only lane 0 carries data, other lanes are dropped
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit_any;
    assign wr_go = psel && penable && pwrite && pstrb[0] && hit_any;

    // read mux straight from the registers; upper bits read zero
    always_comb begin
        prdata = 32'h0000_0000;
        if (hit_mode) begin
            prdata[7:0] = mode_rd(reg_ch, mode_lo_r[reg_ch]);
        end else if (hit_ioab) begin
            prdata[7:0] = ioab_r[reg_ch];
        end else if (hit_iocd) begin
            prdata[7:0] = iocd_r[reg_ch];
        end else if (hit_csel3) begin
            prdata[2:0] = csel3_r;
        end else if (hit_csel4) begin
            prdata[2:0] = csel4_r;
        end
    end

    // per-channel registers, decoders and effective configuration
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        logic [5:0] m_src;
        logic [7:0] ab_src;
        logic [7:0] cd_src;
        tmc_mode_t md;

        // standby reinitialises too; a manual reset never reaches here
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                mode_lo_r[c] <= MODE_RST[5:0];
            end else if (standby_req) begin
                mode_lo_r[c] <= MODE_RST[5:0];
            end else if (wr_go && hit_mode && reg_ch == 3'(c)) begin
                mode_lo_r[c][3:0] <= pwdata[3:0];
                if (tmc_has_cd(c)) begin
                    mode_lo_r[c][BUF_B_BIT] <= pwdata[BUF_B_BIT];
                    mode_lo_r[c][BUF_A_BIT] <= pwdata[BUF_A_BIT];
                end
            end
        end

        // a/b io control register
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                ioab_r[c] <= IOC_RST;
            end else if (standby_req) begin
                ioab_r[c] <= IOC_RST;
            end else if (wr_go && hit_ioab && reg_ch == 3'(c)) begin
                ioab_r[c] <= pwdata[7:0];
            end
        end

        // c/d io control register exists only where c and d do
        if (tmc_has_cd(c)) begin : g_cd
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    iocd_r[c] <= IOC_RST;
                end else if (standby_req) begin
                    iocd_r[c] <= IOC_RST;
                end else if (wr_go && hit_iocd && reg_ch == 3'(c)) begin
                    iocd_r[c] <= pwdata[7:0];
                end
            end
        end else begin : g_no_cd
            assign iocd_r[c] = IOC_RST;
        end

        tmc_mode_dec #(
            .CH(c)
        ) u_dec (
            .mode_field(mode_lo_r[c][3:0]),
            .mode(dec_mode[c]),
            .illegal(dec_bad[c])
        );

        // channel 4 takes channel 3's whole setup while 3 is coupled
        always_comb begin
            m_src = mode_lo_r[c];
            ab_src = ioab_r[c];
            cd_src = iocd_r[c];
            md = dec_mode[c];
            if (c == 4 && coupled3) begin
                m_src = mode_lo_r[3];
                ab_src = ioab_r[3];
                cd_src = iocd_r[3];
                md = dec_mode[3];
            end
            chan_cfg[c].mode = md;
            chan_cfg[c].buf_a = tmc_has_cd(c) && m_src[BUF_A_BIT];
            chan_cfg[c].buf_b = tmc_has_cd(c) && m_src[BUF_B_BIT];
            chan_cfg[c].gen_c_live = tmc_has_cd(c) && !m_src[BUF_A_BIT];
            chan_cfg[c].gen_d_live = tmc_has_cd(c) && !m_src[BUF_B_BIT];
            chan_cfg[c].io_b = ab_src[IO_UPPER_LSB +: 4];
            chan_cfg[c].io_a = ab_src[IO_LOWER_LSB +: 4];
            // buffered registers behave as plain buffers, io field disregarded
            chan_cfg[c].io_d = chan_cfg[c].gen_d_live ? cd_src[IO_UPPER_LSB +: 4] : 4'h0;
            chan_cfg[c].io_c = chan_cfg[c].gen_c_live ? cd_src[IO_LOWER_LSB +: 4] : 4'h0;
        end
    end

    // software-error visibility for the channel datapath
    assign mode_illegal = dec_bad;

    // coupling of channel 4 to channel 3
    assign coupled3 = (dec_mode[3] == MODE_RSYNC) || (dec_mode[3] == MODE_COMP_PEAK) ||
                      (dec_mode[3] == MODE_COMP_VALLEY) || (dec_mode[3] == MODE_COMP_BOTH);
    assign csel4_eff = coupled3 ? csel3_r : csel4_r;

    // clock select registers for channels 3 and 4
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            csel3_r <= CSEL_RST;
        end else if (wr_go && hit_csel3) begin
            csel3_r <= pwdata[2:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            csel4_r <= CSEL_RST;
        end else if (wr_go && hit_csel4) begin
            csel4_r <= pwdata[2:0];
        end
    end

    // shared free-running prescaler; ratios align, so switching keeps phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_cnt_r <= '0;
        end else begin
            pre_cnt_r <= pre_cnt_r + 1'b1;
        end
    end

    // pins are synchronous here; one register gives the rising edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_a_q_r <= 1'b0;
            ext_b_q_r <= 1'b0;
        end else begin
            ext_a_q_r <= ext_count_pin_a;
            ext_b_q_r <= ext_count_pin_b;
        end
    end

    // count enables, edge choice belongs to the neighbouring edge logic
    assign count_tick_3 = tick_for(csel3_r, pre_cnt_r, ext_count_pin_a && !ext_a_q_r,
                                   ext_count_pin_b && !ext_b_q_r);
    assign count_tick_4 = tick_for(csel4_eff, pre_cnt_r, ext_count_pin_a && !ext_a_q_r,
                                   ext_count_pin_b && !ext_b_q_r);

    // checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_div4_quiet;
        ((csel3_r == CSEL_DIV4) && !count_tick_3) [*3];
    endsequence

    sequence s_div4_start;
        (csel3_r == CSEL_DIV4) && count_tick_3;
    endsequence

    mode_rsv_ones_a: assert property (
        (psel && hit_mode) |-> (prdata[7:6] == 2'b11))
        else $error("mode reserved bits not one");

    basic_buf_zero_a: assert property (
        (psel && hit_mode && (reg_ch == 3'h1 || reg_ch == 3'h2)) |-> (prdata[5:4] == 2'b00))
        else $error("basic channel buffer bits not zero");

    standby_init_a: assert property (
        standby_req |=> (mode_rd(0, mode_lo_r[0]) == MODE_RST) && (mode_lo_r[4] == MODE_RST[5:0]))
        else $error("mode register not reinitialised");

    standby_io_a: assert property (
        standby_req |=> (ioab_r[2] == IOC_RST) && (iocd_r[3] == IOC_RST))
        else $error("io control not reinitialised");

    write_next_a: assert property (
        (wr_go && hit_mode && reg_ch == 3'h0 && !standby_req) |=>
            (mode_lo_r[0][3:0] == $past(pwdata[3:0])) && (chan_cfg[0].buf_a == $past(pwdata[4])))
        else $error("mode write not effective next cycle");

    div1_every_a: assert property (
        (csel3_r == CSEL_DIV1) |-> count_tick_3)
        else $error("divide by one missed a cycle");

    div4_gap_a: assert property (
        s_div4_start ##1 s_div4_quiet ##1 (csel3_r == CSEL_DIV4) |-> count_tick_3)
        else $error("divide by four spacing wrong");

    div4_quiet_a: assert property (
        s_div4_start ##1 (csel3_r == CSEL_DIV4) |-> !count_tick_3)
        else $error("divide by four ticked early");

    div1024_a: assert property (
        ((csel3_r == CSEL_DIV1024) && count_tick_3) |-> $past(pre_cnt_r) == 10'h3ff)
        else $error("divide by 1024 ticked off phase");

    ext_a_edge_a: assert property (
        (csel3_r == CSEL_EXT_A) |-> (count_tick_3 == (ext_count_pin_a && !$past(ext_count_pin_a))))
        else $error("external pin a count wrong");

    buf_c_off_a: assert property (
        chan_cfg[0].buf_a |-> (!chan_cfg[0].gen_c_live && chan_cfg[0].io_c == 4'h0))
        else $error("buffered c still live");

    ch4_follow_a: assert property (
        coupled3 |-> (chan_cfg[4].mode == chan_cfg[3].mode) && (count_tick_4 == count_tick_3))
        else $error("channel 4 not following channel 3");

    no_phase_ch0_a: assert property (
        (mode_lo_r[0][3:2] == 2'b01) |-> (chan_cfg[0].mode == MODE_RESERVED) && mode_illegal[0])
        else $error("phase mode accepted on channel 0");
endmodule
`default_nettype wire

// *** test_timer_channel_mode_config.sv ***
`default_nettype none
module test_timer_channel_mode_config;
    timeunit 1ns;
    timeprecision 1ps;
    import tmc_pkg::*;

    // stimulus and observed signals
    logic pclk, presetn, psel, penable, pwrite, standby_req;
    logic ext_count_pin_a, ext_count_pin_b;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic pready, pslverr, count_tick_3, count_tick_4, err;
    tmc_chan_cfg_t chan_cfg [NUM_CH];
    logic [NUM_CH-1:0] mode_illegal;
    int error_cnt = 0;
    int n_tests = 0;
    int cnt;
    // internal divides then pin a (every 5th cycle) and pin b (every 7th) over 2048 cycles
    int exp_tab [8] = '{2048, 512, 128, 32, 8, 2, 410, 293};

    tmc_top dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .standby_req(standby_req), .ext_count_pin_a(ext_count_pin_a),
        .ext_count_pin_b(ext_count_pin_b), .count_tick_3(count_tick_3),
        .count_tick_4(count_tick_4), .chan_cfg(chan_cfg), .mode_illegal(mode_illegal)
    );

    // free-running clock
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // hang guard at 62.5k cycles, well beyond the ~35k cycles the tests need
    initial begin
        #500_000;
        error_cnt++;
        end_sim;
    end

    function automatic logic [11:0] mode_a(int c);
        return OFF_MODE_BASE + 12'(4 * c);
    endfunction
    function automatic logic [11:0] ioab_a(int c);
        return OFF_IOAB_BASE + 12'(4 * c);
    endfunction
    function automatic logic [11:0] iocd_a(int c);
        return OFF_IOCD_BASE + 12'(4 * c);
    endfunction

    // expected decode of the mode field, channel limits handled apart
    function automatic tmc_mode_t exp_mode(int code);
        case (code)
            0: return MODE_NORMAL;
            2: return MODE_PWM1;
            3: return MODE_PWM2;
            4: return MODE_PHASE1;
            5: return MODE_PHASE2;
            6: return MODE_PHASE3;
            7: return MODE_PHASE4;
            8: return MODE_RSYNC;
            13: return MODE_COMP_PEAK;
            14: return MODE_COMP_VALLEY;
            15: return MODE_COMP_BOTH;
            default: return MODE_RESERVED;
        endcase
    endfunction
    function automatic bit legal(int ch, int code);
        if (code >= 4 && code <= 7) begin
            return ch == 1 || ch == 2;
        end
        if (code >= 8) begin
            return ch == 3;
        end
        return !(code == 3 && ch >= 3);
    endfunction

    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_bit(input string what, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic chk_mode(input string what, input tmc_mode_t exp, input tmc_mode_t got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    // one apb transfer; entered at a rising edge, returns one idle edge after the access
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int k;
        k = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 100);
        if (k >= 100) error_cnt++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // idle edge, so the next call never reassigns psel in this time step
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, 32'(d), 4'hf);
    endtask
    task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, 4'h0);
        chk_word(what, exp, rd);
    endtask

    // count ticks over 2048 cycles while both pins pulse; read at the edge closing each cycle
    task automatic run_ticks(input bit sel4, output int n);
        n = 0;
        for (int i = 0; i < 2048; i++) begin
            ext_count_pin_a <= (i % 5 == 0);
            ext_count_pin_b <= (i % 7 == 0);
            @(posedge pclk);
            if ((sel4 ? count_tick_4 : count_tick_3) === 1'b1) n++;
        end
        ext_count_pin_a <= 1'b0;
        ext_count_pin_b <= 1'b0;
    endtask

    task automatic end_sim;
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, standby_req, ext_count_pin_a, ext_count_pin_b} = '0;
        paddr = '0;
        pwdata = '0;
        pstrb = '0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // reset values of every register except the channel 4 clock select
        for (int c = 0; c < 5; c++) begin
            rd_chk("mode reset", mode_a(c), 32'h0000_00c0);
            rd_chk("ioab reset", ioab_a(c), 32'h0000_0000);
            if (c == 0 || c >= 3) rd_chk("iocd reset", iocd_a(c), 32'h0000_0000);
        end
        rd_chk("clock select reset", OFF_CSEL3, 32'h0000_0000);
        apb(1'b1, 12'h044, 32'h0000_00ff, 4'hf);
        chk_bit("unmapped error", 1'b1, err);
        // fixed bits and reserved buffer bits
        wr(mode_a(0), 8'hff);
        rd_chk("mode ch0 all ones", mode_a(0), 32'h0000_00ff);
        wr(mode_a(0), 8'h00);
        rd_chk("mode ch0 zeros", mode_a(0), 32'h0000_00c0);
        wr(mode_a(1), 8'h30);
        rd_chk("mode ch1 buffers", mode_a(1), 32'h0000_00c0);
        chk_bit("ch1 buffer a", 1'b0, chan_cfg[1].buf_a);
        apb(1'b1, mode_a(2), 32'h0000_0002, 4'he);
        rd_chk("strobe off write", mode_a(2), 32'h0000_00c0);
        // every allowed mode code on every channel; forbidden phase codes, and codes 8 and 13-15 on channels 0-2, are written too
        for (int c = 0; c < 5; c++) begin
            for (int m = 0; m < 16; m++) begin
                if (m == 1 || (m >= 9 && m <= 12) || (c >= 3 && m == 3)) continue;
                if (c == 4 && m >= 8) continue;
                wr(mode_a(c), 8'(m));
                chk_bit("mode illegal", !legal(c, m), mode_illegal[c]);
                if (legal(c, m)) chk_mode("mode decode", exp_mode(m), chan_cfg[c].mode);
            end
            wr(mode_a(c), 8'h00);
        end
        // io fields and buffer pairing on the full channels
        for (int c = 0; c < 5; c++) begin
            if (c == 1 || c == 2) continue;
            wr(ioab_a(c), 8'h3c);
            wr(iocd_a(c), 8'h5a);
            chk_word("io fields", 32'h0000_5a3c, 32'({chan_cfg[c].io_d, chan_cfg[c].io_c,
                chan_cfg[c].io_b, chan_cfg[c].io_a}));
            chk_word("live flags", 32'h0000_0003, 32'({chan_cfg[c].buf_a, chan_cfg[c].buf_b,
                chan_cfg[c].gen_c_live, chan_cfg[c].gen_d_live}));
            wr(mode_a(c), 8'h10);
            chk_word("io buffer a", 32'h0000_503c, 32'({chan_cfg[c].io_d, chan_cfg[c].io_c,
                chan_cfg[c].io_b, chan_cfg[c].io_a}));
            chk_word("flags buffer a", 32'h0000_0009, 32'({chan_cfg[c].buf_a, chan_cfg[c].buf_b,
                chan_cfg[c].gen_c_live, chan_cfg[c].gen_d_live}));
            wr(mode_a(c), 8'h20);
            chk_word("io buffer b", 32'h0000_0a3c, 32'({chan_cfg[c].io_d, chan_cfg[c].io_c,
                chan_cfg[c].io_b, chan_cfg[c].io_a}));
            chk_word("flags buffer b", 32'h0000_0006, 32'({chan_cfg[c].buf_a, chan_cfg[c].buf_b,
                chan_cfg[c].gen_c_live, chan_cfg[c].gen_d_live}));
            rd_chk("iocd kept", iocd_a(c), 32'h0000_005a);
            wr(mode_a(c), 8'h00);
        end
        // clock select codes on both channels
        for (int s = 0; s < 2; s++) begin
            for (int k = 0; k < 8; k++) begin
                wr(s ? OFF_CSEL4 : OFF_CSEL3, 8'(k));
                run_ticks(s[0], cnt);
                chk_word("tick count", 32'(exp_tab[k]), 32'(cnt));
            end
        end
        // channel 4 follows channel 3 in coupled modes
        wr(ioab_a(4), 8'h11);
        wr(ioab_a(3), 8'h77);
        wr(OFF_CSEL3, 8'h02);
        wr(OFF_CSEL4, 8'h00);
        wr(mode_a(3), 8'h08);
        chk_mode("ch4 follows", MODE_RSYNC, chan_cfg[4].mode);
        chk_word("ch4 io follows", 32'h0000_0007, 32'(chan_cfg[4].io_a));
        run_ticks(1'b1, cnt);
        chk_word("ch4 ticks follow", 32'h0000_0080, 32'(cnt));
        wr(mode_a(3), 8'h0d);
        chk_mode("ch4 follows peak", MODE_COMP_PEAK, chan_cfg[4].mode);
        wr(mode_a(3), 8'h00);
        chk_word("ch4 own io", 32'h0000_0001, 32'(chan_cfg[4].io_a));
        // standby reinitialises, then a second power-on reset
        wr(mode_a(2), 8'h02);
        wr(iocd_a(3), 8'h99);
        standby_req <= 1'b1;
        @(posedge pclk);
        standby_req <= 1'b0;
        rd_chk("mode after standby", mode_a(2), 32'h0000_00c0);
        rd_chk("iocd after standby", iocd_a(3), 32'h0000_0000);
        wr(ioab_a(1), 8'h55);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd_chk("ioab after reset", ioab_a(1), 32'h0000_0000);
        rd_chk("clock select after reset", OFF_CSEL3, 32'h0000_0000);
        end_sim;
    end
endmodule
`default_nettype wire
